/* File: hdl/cea_regs.sv */
// Interrupt mask, interrupt status, arbitration loss capture and bus error
// capture registers of a CAN controller, on an AHB-Lite slave port.
// Assumes the bit stream processor drives single-cycle event strobes with
// their data valid in the same cycle, all synchronous to mclk_in.
module cea_regs (
  // Clock and reset.
  input wire logic mclk_in,
  input wire logic reset_in,
  // AHB-Lite slave port.
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  output logic [31:0] hrdata_out,
  output logic hreadyout_out,
  output logic hresp_out,
  // Events from the bit stream processor.
  input wire logic arb_loss_in,
  input wire logic [4:0] arb_loss_position_in,
  input wire logic bus_error_in,
  input wire cea_pkg::cea_class_t error_class_in,
  input wire logic error_rx_in,
  input wire cea_pkg::cea_seg_t frame_segment_code_in,
  input wire logic passive_change_in,
  input wire logic overrun_in,
  input wire logic warning_in,
  input wire logic transmit_in,
  input wire logic receive_in,
  // Interrupt request.
  output logic irq_out
);

  // Returns one when the address selects the register of the given index.
  function automatic logic reg_hit(input logic [31:0] addr,
                                   input logic [7:0] idx);
    reg_hit = (addr[cea_pkg::IDX_MSB:cea_pkg::IDX_LSB] == idx);
  endfunction

  logic [7:0] interrupt_source_mask;
  logic [7:0] interrupt_status;
  logic wr_pend;
  logic [31:0] wr_addr;
  logic [7:0] next_mask;
  logic [7:0] next_status;
  logic next_wr_pend;
  logic [31:0] next_wr_addr;
  logic [31:0] next_hrdata;
  logic next_irq;
  logic addr_take;
  logic rd_take;
  logic [7:0] events;
  logic [cea_pkg::POS_W-1:0] arbitration_loss_position;
  logic [cea_pkg::ERR_W-1:0] bus_error_capture;
  logic [cea_pkg::ERR_W-1:0] error_record;
  logic arb_armed;
  logic err_armed;
  logic arb_rearm;
  logic err_rearm;
  logic [7:0] w1c;

  assign addr_take = hsel_in && hready_in &&
                     htrans_in[cea_pkg::HTRANS_ACTIVE_BIT];
  assign rd_take = addr_take && !hwrite_in;
  // Reading a capture register re-arms it.
  assign arb_rearm = rd_take && reg_hit(haddr_in, cea_pkg::ARB_IDX);
  assign err_rearm = rd_take && reg_hit(haddr_in, cea_pkg::ERR_IDX);

  // Error record: class, direction and segment.
  always_comb begin
    error_record = cea_pkg::ERR_RESET;
    error_record[cea_pkg::ERR_W-1:cea_pkg::CLASS_LSB] = error_class_in;
    error_record[cea_pkg::DIR_BIT] = error_rx_in;
    error_record[cea_pkg::SEG_W-1:0] = frame_segment_code_in;
  end

  cea_capture #(
    .WIDTH(cea_pkg::POS_W),
    .RESET_VALUE(cea_pkg::ARB_RESET)
  ) arb_cap (
    .mclk_in(mclk_in),
    .reset_in(reset_in),
    .load_in(arb_loss_in),
    .data_in(arb_loss_position_in),
    .rearm_in(arb_rearm),
    .value_out(arbitration_loss_position),
    .armed_out(arb_armed)
  );

  cea_capture #(
    .WIDTH(cea_pkg::ERR_W),
    .RESET_VALUE(cea_pkg::ERR_RESET)
  ) err_cap (
    .mclk_in(mclk_in),
    .reset_in(reset_in),
    .load_in(bus_error_in),
    .data_in(error_record),
    .rearm_in(err_rearm),
    .value_out(bus_error_capture),
    .armed_out(err_armed)
  );

  // Interrupt sources in mask layout; the reserved position never fires.
  always_comb begin
    events = 8'h00;
    events[cea_pkg::BIT_BUS] = bus_error_in;
    events[cea_pkg::BIT_ARB] = arb_loss_in;
    events[cea_pkg::BIT_PASSIVE] = passive_change_in;
    events[cea_pkg::BIT_OVERRUN] = overrun_in;
    events[cea_pkg::BIT_WARNING] = warning_in;
    events[cea_pkg::BIT_TRANSMIT] = transmit_in;
    events[cea_pkg::BIT_RECEIVE] = receive_in;
  end

  // Bus side: address phase capture, register writes and read data.
  always_comb begin
    next_wr_pend = addr_take && hwrite_in;
    next_wr_addr = addr_take ? haddr_in : wr_addr;
    next_mask = interrupt_source_mask;
    w1c = 8'h00;
    if (wr_pend && reg_hit(wr_addr, cea_pkg::MASK_IDX)) begin
      next_mask = hwdata_in[7:0] & cea_pkg::SRC_USED;
    end
    if (wr_pend && reg_hit(wr_addr, cea_pkg::FLAG_IDX)) begin
      w1c = hwdata_in[7:0];
    end
    next_hrdata = cea_pkg::DATA_ZERO;
    if (rd_take) begin
      if (reg_hit(haddr_in, cea_pkg::MASK_IDX)) begin
        next_hrdata[7:0] = interrupt_source_mask;
      end else if (reg_hit(haddr_in, cea_pkg::FLAG_IDX)) begin
        next_hrdata[7:0] = interrupt_status;
      end else if (reg_hit(haddr_in, cea_pkg::ARB_IDX)) begin
        next_hrdata[cea_pkg::POS_W-1:0] = arbitration_loss_position;
      end else if (reg_hit(haddr_in, cea_pkg::ERR_IDX)) begin
        next_hrdata[cea_pkg::ERR_W-1:0] = bus_error_capture;
      end
    end
    // A new event wins over a write-one-to-clear in the same cycle.
    next_status = (interrupt_status & ~w1c) |
                  (events & interrupt_source_mask);
    next_irq = |(interrupt_status & interrupt_source_mask);
  end

  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      interrupt_source_mask <= cea_pkg::MASK_RESET;
      interrupt_status <= cea_pkg::FLAG_RESET;
      wr_pend <= 1'b0;
      wr_addr <= cea_pkg::DATA_ZERO;
      hrdata_out <= cea_pkg::DATA_ZERO;
      hreadyout_out <= 1'b1;
      hresp_out <= cea_pkg::HRESP_OKAY;
      irq_out <= 1'b0;
    end else begin
      interrupt_source_mask <= next_mask;
      interrupt_status <= next_status;
      wr_pend <= next_wr_pend;
      wr_addr <= next_wr_addr;
      hrdata_out <= next_hrdata;
      hreadyout_out <= 1'b1;
      hresp_out <= cea_pkg::HRESP_OKAY;
      irq_out <= next_irq;
    end
  end

  // Checks.
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (reset_in);

  sequence arb_read_addr_s;
    rd_take && reg_hit(haddr_in, cea_pkg::ARB_IDX);
  endsequence

  sequence arb_read_data_s;
    hreadyout_out && hrdata_out[7:cea_pkg::POS_W] == 3'h0 &&
    hrdata_out[cea_pkg::POS_W-1:0] == $past(arbitration_loss_position);
  endsequence

  sequence err_read_addr_s;
    rd_take && reg_hit(haddr_in, cea_pkg::ERR_IDX);
  endsequence

  sequence err_read_data_s;
    hreadyout_out && hrdata_out == {24'h0, $past(bus_error_capture)};
  endsequence

  mask_write_a: assert property (
    wr_pend && reg_hit(wr_addr, cea_pkg::MASK_IDX) |=>
    interrupt_source_mask == ($past(hwdata_in[7:0]) & cea_pkg::SRC_USED))
    else $error("mask register did not take written value");

  arb_capture_a: assert property (
    arb_loss_in && arb_armed |=>
    arbitration_loss_position == $past(arb_loss_position_in) && !arb_armed)
    else $error("arbitration loss position not captured");

  arb_hold_a: assert property (
    !arb_armed && !arb_rearm |=> $stable(arbitration_loss_position))
    else $error("arbitration capture changed while held");

  arb_read_a: assert property (
    arb_read_addr_s |=> arb_read_data_s)
    else $error("arbitration capture read data wrong");

  err_capture_a: assert property (
    bus_error_in && err_armed |=>
    bus_error_capture[cea_pkg::SEG_W-1:0] == $past(frame_segment_code_in) &&
    bus_error_capture[cea_pkg::DIR_BIT] == $past(error_rx_in) &&
    bus_error_capture[7:cea_pkg::CLASS_LSB] == $past(error_class_in))
    else $error("bus error record not captured");

  err_hold_a: assert property (
    !err_armed && !err_rearm |=> $stable(bus_error_capture) && !err_armed)
    else $error("error capture changed while held");

  err_read_a: assert property (
    err_read_addr_s |=> err_read_data_s and
    (err_armed || $past(bus_error_in)))
    else $error("error capture read or re-arm wrong");

  flag_gate_a: assert property (
    ((interrupt_status & ~$past(interrupt_status)) &
     ~$past(interrupt_source_mask)) == 8'h00)
    else $error("status flag set with its mask bit clear");

  arb_flag_a: assert property (
    arb_loss_in && interrupt_source_mask[cea_pkg::BIT_ARB] |=>
    interrupt_status[cea_pkg::BIT_ARB] ##1 irq_out)
    else $error("arbitration loss flag or interrupt missing");

  bus_flag_a: assert property (
    bus_error_in && interrupt_source_mask[cea_pkg::BIT_BUS] |=>
    interrupt_status[cea_pkg::BIT_BUS] ##1 irq_out)
    else $error("bus error flag or interrupt missing");

  irq_level_a: assert property (
    irq_out == |($past(interrupt_status) & $past(interrupt_source_mask)))
    else $error("interrupt output does not follow status and mask");

  okay_ready_a: assert property (
    hreadyout_out && hresp_out == cea_pkg::HRESP_OKAY)
    else $error("slave must answer ready and OKAY");

endmodule

/* File: hdl/cea_pkg.sv */
// Constants, field layouts and encodings of the CAN error and arbitration
// capture block.
// Assumes an AHB-Lite master with 32-bit data and one synchronous clock.
//
// Summary of operation
// - Mask bit 7 enables bus error interrupts; mask resets to a fixed value.
// - Mask bit 6 enables arbitration loss, bit 5 error passive interrupts.
// - Mask bit 3 enables data overrun interrupts; bit 4 is reserved.
// - Mask bits 2, 1, 0 enable warning, transmit and receive interrupts.
// - On arbitration loss, the current bit position is captured.
// - A captured position holds until the CPU reads it; the read re-arms.
// - Position n in bits 4:0 means loss in identifier bit n+1; 7:5 read zero.
// - On a bus error its kind and frame location are captured; reset zero.
// - Class bits 7:6: bit, form, stuff or other error.
// - Bit 5 is one for an error while receiving, zero while transmitting.
// - Bits 4:0 hold the frame segment code of the error.
// - Segment codes follow the fixed frame segment mapping.
// - A status flag sets only while its mask bit is one.
// - The arbitration loss flag sets on a loss when its mask bit is one.
// - The bus error flag sets on a bus error when its mask bit is one.
package cea_pkg;

  // Register indices; the byte address is four times the index.
  localparam logic [7:0] FLAG_IDX = 8'h03;
  localparam logic [7:0] MASK_IDX = 8'h04;
  localparam logic [7:0] ARB_IDX = 8'h0b;
  localparam logic [7:0] ERR_IDX = 8'h0c;
  localparam int IDX_LSB = 2;
  localparam int IDX_MSB = 9;

  // Reset values.
  localparam logic [7:0] MASK_RESET = 8'h00;
  localparam logic [7:0] FLAG_RESET = 8'h00;
  localparam logic [4:0] ARB_RESET = 5'h00;
  localparam logic [7:0] ERR_RESET = 8'h00;
  localparam logic [31:0] DATA_ZERO = 32'h0000_0000;

  // Interrupt source bit positions, shared by mask and flag registers.
  localparam int BIT_BUS = 7;
  localparam int BIT_ARB = 6;
  localparam int BIT_PASSIVE = 5;
  localparam int BIT_RSVD = 4;
  localparam int BIT_OVERRUN = 3;
  localparam int BIT_WARNING = 2;
  localparam int BIT_TRANSMIT = 1;
  localparam int BIT_RECEIVE = 0;
  localparam logic [7:0] SRC_USED = 8'hef;

  // Field widths and positions of the capture registers.
  localparam int POS_W = 5;
  localparam int ERR_W = 8;
  localparam int CLASS_LSB = 6;
  localparam int DIR_BIT = 5;
  localparam int SEG_W = 5;

  // AHB-Lite encodings.
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam int HTRANS_ACTIVE_BIT = 1;
  localparam logic HRESP_OKAY = 1'b0;

  typedef enum logic [1:0] {
    CEA_BIT_ERR = 2'h0,
    CEA_FORM_ERR = 2'h1,
    CEA_STUFF_ERR = 2'h2,
    CEA_OTHER_ERR = 2'h3
  } cea_class_t;

  typedef enum logic [4:0] {
    CEA_SEG_SOF = 5'h03,
    CEA_SEG_ID28_21 = 5'h02,
    CEA_SEG_ID20_18 = 5'h06,
    CEA_SEG_SRTR = 5'h04,
    CEA_SEG_IDE = 5'h05,
    CEA_SEG_ID17_13 = 5'h07,
    CEA_SEG_ID12_5 = 5'h0f,
    CEA_SEG_ID4_0 = 5'h0e,
    CEA_SEG_RTR = 5'h0c,
    CEA_SEG_RSVD1 = 5'h0d,
    CEA_SEG_RSVD0 = 5'h09,
    CEA_SEG_DLC = 5'h0b,
    CEA_SEG_DATA = 5'h0a,
    CEA_SEG_CRC = 5'h08,
    CEA_SEG_CRC_DELIM = 5'h18,
    CEA_SEG_ACK_SLOT = 5'h19,
    CEA_SEG_ACK_DELIM = 5'h1b,
    CEA_SEG_EOF = 5'h1a,
    CEA_SEG_INTERMISSION = 5'h12,
    CEA_SEG_ACTIVE_FLAG = 5'h11,
    CEA_SEG_PASSIVE_FLAG = 5'h16,
    CEA_SEG_TOLERATE_DOM = 5'h13,
    CEA_SEG_ERR_DELIM = 5'h17,
    CEA_SEG_OVERLOAD = 5'h1c
  } cea_seg_t;

endpackage

/* File: hdl/cea_capture.sv */
// One-shot capture register: loads once, then holds until re-armed by a read.
// Assumes load and rearm are synchronous single-cycle strobes.
module cea_capture #(
  parameter int WIDTH = 8,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
  // Clock and reset.
  input wire logic mclk_in,
  input wire logic reset_in,
  // Capture control.
  input wire logic load_in,
  input wire logic [WIDTH-1:0] data_in,
  input wire logic rearm_in,
  // Captured state.
  output logic [WIDTH-1:0] value_out,
  output logic armed_out
);

  logic [WIDTH-1:0] next_value;
  logic next_armed;

  // A load in the re-arm cycle is still taken, so no event is lost.
  always_comb begin
    next_value = value_out;
    next_armed = armed_out;
    if (load_in && (armed_out || rearm_in)) begin
      next_value = data_in;
      next_armed = 1'b0;
    end else if (rearm_in) begin
      next_armed = 1'b1;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      value_out <= RESET_VALUE;
      armed_out <= 1'b1;
    end else begin
      value_out <= next_value;
      armed_out <= next_armed;
    end
  end

endmodule

/* File: tb/cea_bsp_model.sv */
// Behavioural bit stream processor: drives event strobes and their data.
// Assumes the caller starts each event just after a rising clock edge.
module cea_bsp_model (
  // Clock.
  input wire logic mclk_in,
  // Event strobes and their data.
  output logic arb_loss_out,
  output logic [4:0] arb_loss_position_out,
  output logic bus_error_out,
  output cea_pkg::cea_class_t error_class_out,
  output logic error_rx_out,
  output cea_pkg::cea_seg_t frame_segment_code_out,
  output logic passive_change_out,
  output logic overrun_out,
  output logic warning_out,
  output logic transmit_out,
  output logic receive_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    {arb_loss_out, bus_error_out, passive_change_out} = 3'h0;
    {overrun_out, warning_out, transmit_out, receive_out} = 4'h0;
    arb_loss_position_out = 5'h00;
    error_class_out = cea_pkg::CEA_BIT_ERR;
    error_rx_out = 1'b0;
    frame_segment_code_out = cea_pkg::CEA_SEG_SOF;
  end

  // Pulses the strobes picked by which for one cycle; data lines then
  // show the inverse so that stale data is never taken for valid.
  task automatic fire(input logic [7:0] which, input logic [4:0] pos,
                      input logic [7:0] rec);
    bus_error_out <= which[7];
    arb_loss_out <= which[6];
    passive_change_out <= which[5];
    overrun_out <= which[3];
    warning_out <= which[2];
    transmit_out <= which[1];
    receive_out <= which[0];
    arb_loss_position_out <= pos;
    error_class_out <= cea_pkg::cea_class_t'(rec[7:6]);
    error_rx_out <= rec[5];
    frame_segment_code_out <= cea_pkg::cea_seg_t'(rec[4:0]);
    @(posedge mclk_in);
    {arb_loss_out, bus_error_out, passive_change_out} <= 3'h0;
    {overrun_out, warning_out, transmit_out, receive_out} <= 4'h0;
    arb_loss_position_out <= ~pos;
    error_class_out <= cea_pkg::cea_class_t'(~rec[7:6]);
    error_rx_out <= ~rec[5];
    frame_segment_code_out <= cea_pkg::cea_seg_t'(~rec[4:0]);
    @(posedge mclk_in);
  endtask
endmodule

/* File: tb/tb_can_error_arbitration_capture.sv */
// Self-checking bench: register access over AHB-Lite plus bus events.
// Assumes a zero-wait-state slave and the behavioural event model.
module tb_can_error_arbitration_capture;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk_in = 1'b0;
  logic reset_in, hsel_in, hwrite_in;
  logic [31:0] haddr_in, hwdata_in, hrdata_out;
  logic [1:0] htrans_in;
  logic [2:0] hsize_in;
  logic hreadyout_out, hresp_out, irq_out;
  logic arb_l, bus_e, rx_e, pas_e, ovr_e, wrn_e, tx_e, rcv_e;
  logic [4:0] pos_e;
  cea_pkg::cea_class_t cls_e;
  cea_pkg::cea_seg_t seg_e;
  int mismatches = 0;
  int checked = 0;
  logic [7:0] recs [4] = '{8'h23, 8'h48, 8'hb9, 8'hda};

  always #4 mclk_in = ~mclk_in;

  cea_regs cea_regs_inst (.mclk_in(mclk_in), .reset_in(reset_in),
    .hsel_in(hsel_in), .haddr_in(haddr_in), .htrans_in(htrans_in),
    .hwrite_in(hwrite_in), .hsize_in(hsize_in), .hwdata_in(hwdata_in),
    .hready_in(hreadyout_out), .hrdata_out(hrdata_out),
    .hreadyout_out(hreadyout_out), .hresp_out(hresp_out),
    .arb_loss_in(arb_l), .arb_loss_position_in(pos_e),
    .bus_error_in(bus_e), .error_class_in(cls_e), .error_rx_in(rx_e),
    .frame_segment_code_in(seg_e), .passive_change_in(pas_e),
    .overrun_in(ovr_e), .warning_in(wrn_e), .transmit_in(tx_e),
    .receive_in(rcv_e), .irq_out(irq_out));

  cea_bsp_model cea_bsp_model_inst (.mclk_in(mclk_in),
    .arb_loss_out(arb_l), .arb_loss_position_out(pos_e),
    .bus_error_out(bus_e), .error_class_out(cls_e), .error_rx_out(rx_e),
    .frame_segment_code_out(seg_e), .passive_change_out(pas_e),
    .overrun_out(ovr_e), .warning_out(wrn_e), .transmit_out(tx_e),
    .receive_out(rcv_e));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict();
    if (mismatches == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic wait_ready();
    int n;
    n = 0;
    do begin
      @(posedge mclk_in);
      n++;
    end while (hreadyout_out !== 1'b1 && n < 16);
    if (hreadyout_out !== 1'b1) begin
      mismatches++;
      $display("BAD %0t bus never ready", $time);
      print_verdict();
    end
  endtask

  task automatic ahb(input logic wr, input logic [7:0] idx,
                     input logic [31:0] wd, output logic [31:0] rd);
    hsel_in <= 1'b1;
    htrans_in <= cea_pkg::HTRANS_NONSEQ;
    haddr_in <= {22'h0, idx, 2'h0};
    hwrite_in <= wr;
    wait_ready();
    htrans_in <= 2'h0;
    hwdata_in <= wd;
    wait_ready();
    rd = hrdata_out;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    logic [31:0] y;
    ahb(1'b1, idx, d, y);
  endtask

  task automatic rd_check(input logic [7:0] idx, input logic [31:0] exp);
    logic [31:0] y;
    ahb(1'b0, idx, 32'h0, y);
    check(y, exp);
  endtask

  task automatic irq_check(input logic exp);
    @(posedge mclk_in);
    check({31'h0, irq_out}, {31'h0, exp});
  endtask

  initial begin
    reset_in = 1'b1;
    hsel_in = 1'b0;
    hwrite_in = 1'b0;
    haddr_in = 32'h0;
    hwdata_in = 32'h0;
    htrans_in = 2'h0;
    hsize_in = 3'h2;
    repeat (5) @(posedge mclk_in);
    reset_in <= 1'b0;
    @(posedge mclk_in);
    rd_check(cea_pkg::MASK_IDX, 32'h00);
    rd_check(cea_pkg::FLAG_IDX, 32'h00);
    rd_check(cea_pkg::ARB_IDX, 32'h00);
    rd_check(cea_pkg::ERR_IDX, 32'h00);
    rd_check(8'h3f, 32'h00);
    check({31'h0, hresp_out}, 32'h0);
    wr(cea_pkg::MASK_IDX, 32'hff);
    rd_check(cea_pkg::MASK_IDX, 32'hef);
    // Each source alone: enabled it raises flag and irq, masked it does not.
    for (int b = 0; b < 8; b++) begin
      if (b != cea_pkg::BIT_RSVD) begin
        wr(cea_pkg::MASK_IDX, 32'h1 << b);
        rd_check(cea_pkg::MASK_IDX, 32'h1 << b);
        cea_bsp_model_inst.fire(8'h1 << b, 5'h0a, 8'hd9);
        irq_check(1'b1);
        rd_check(cea_pkg::FLAG_IDX, 32'h1 << b);
        wr(cea_pkg::FLAG_IDX, 32'h1 << b);
        wr(cea_pkg::MASK_IDX, 32'h0);
        cea_bsp_model_inst.fire(8'h1 << b, 5'h15, 8'h26);
        irq_check(1'b0);
        rd_check(cea_pkg::FLAG_IDX, 32'h0);
      end
    end
    // Arbitration position holds until read, then captures again.
    rd_check(cea_pkg::ARB_IDX, 32'h0a);
    cea_bsp_model_inst.fire(8'h40, 5'h1f, 8'h00);
    cea_bsp_model_inst.fire(8'h40, 5'h05, 8'h00);
    rd_check(cea_pkg::ARB_IDX, 32'h1f);
    wr(cea_pkg::ARB_IDX, 32'hff);
    rd_check(cea_pkg::ARB_IDX, 32'h1f);
    cea_bsp_model_inst.fire(8'h40, 5'h00, 8'h00);
    rd_check(cea_pkg::ARB_IDX, 32'h00);
    // Error record: every class, both directions, several segments.
    rd_check(cea_pkg::ERR_IDX, 32'hd9);
    for (int i = 0; i < 4; i++) begin
      cea_bsp_model_inst.fire(8'h80, 5'h00, recs[i]);
      cea_bsp_model_inst.fire(8'h80, 5'h00, ~recs[i]);
      rd_check(cea_pkg::ERR_IDX, {24'h0, recs[i]});
    end
    wr(cea_pkg::ERR_IDX, 32'h00);
    rd_check(cea_pkg::ERR_IDX, 32'hda);
    print_verdict();
  end
endmodule
